// ---- rtl/fhr_pkg.sv ----
// package for the fault history recall block: timing, types, states
package fhr_pkg;
  // clock and timing base
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned TICK_NS = 100_000_000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
  localparam int unsigned DEB_NS = 20_000_000;
  localparam int unsigned DEB_CYC = DEB_NS / CLK_NS;
  // hold windows and display times, in tenths of a second
  localparam logic [8:0] T_REVIEW_LO = 9'h014;
  localparam logic [8:0] T_REVIEW_HI = 9'h032;
  localparam logic [8:0] T_CLEAR_LO = 9'h064;
  localparam logic [8:0] T_CLEAR_HI = 9'h096;
  localparam logic [8:0] T_BLINK = 9'h005;
  localparam logic [8:0] T_END = 9'h01E;
  localparam logic [8:0] T_EIGHTS = 9'h01E;
  localparam logic [8:0] T_REVIEW_OUT = 9'h12C;
  // history shape
  localparam int unsigned HIST_DEPTH = 6;
  localparam logic [2:0] HIST_FULL = 3'h6;
  localparam logic [1:0] REPEAT_MAX = 2'h3;
  // reset values
  localparam logic [7:0] CODE_RST = 8'h00;

  typedef logic [7:0] fhr_code_t;
  typedef enum logic [1:0] {DK_BLANK, DK_CODE, DK_DASH, DK_EIGHT} fhr_kind_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_HOLD, ST_SHOW, ST_NEXT, ST_END, ST_EIGHT
  } fhr_state_e;
  // one fault code with its qualifier
  typedef struct packed {
    logic valid;
    fhr_code_t code;
  } fhr_fault_s;
  // what the two-digit display driver shows; lit low blanks a blink phase
  typedef struct packed {
    logic lit;
    fhr_kind_e kind;
    fhr_code_t code;
  } fhr_disp_s;
endpackage

// ---- rtl/fhr_recall.sv ----
// fault history recall and clear controller for the service button
// Summary of operation
// RULE_01: active fault codes are shown on the two-digit display
// RULE_02: the six most recent faults are kept and can be reviewed
// RULE_03: button sequences are accepted only with no thermostat demand; a clear release in the cycle demand arrives still erases history
// RULE_04: holding the button 2 to 5 seconds shows a steady double dash
// RULE_05: release within 2 to 5 seconds shows the newest stored fault
// RULE_06: each later press steps to the next older stored fault
// RULE_07: after the last fault the double dash blinks, then standby
// RULE_08: a run of identical faults is shown at most three times
// RULE_09: holding 10 to 15 seconds blinks the double dash, clear armed
// RULE_10: release within 10 to 15 seconds erases history and shows 88
// RULE_11: release before 2 seconds returns to standby with no history
// RULE_12: release between 5 and 10 seconds does nothing, back to standby
// RULE_13: holding past 15 seconds cancels the clear, history kept
// RULE_14: button is debounced and hold time counted in tenths of a second
`timescale 1ns/100ps
module fhr_recall
  import fhr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned DEB_CYCLES = DEB_CYC
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // pins from the board
  input wire logic I_RECALL_BTN,
  input wire logic I_DEMAND,
  // fault log side
  input wire fhr_fault_s I_ACTIVE_FAULT,
  input wire fhr_fault_s I_LOG_FAULT,
  // display driver side
  output fhr_disp_s O_DISP,
  output logic [2:0] O_HIST_COUNT
);

  // blink phase from a tenths timer, lit during even half periods
  function automatic logic blink_on(input logic [8:0] t);
    logic [8:0] half;
    half = t / T_BLINK;
    return ~half[0];
  endfunction

  // pin synchronisers, debounce and tenths prescaler state
  logic btn_s1_r, btn_s2_r, dem_s1_r, dem_s2_r;
  logic btn_q_r, btn_q_nxt, press_r, press_nxt;
  logic [18:0] deb_r, deb_nxt;
  logic [20:0] pre_r, pre_nxt;
  logic tick_r, tick_nxt;

  // debounce needs the level stable for the whole window before it counts
  always_comb begin
    btn_q_nxt = btn_q_r;
    deb_nxt = '0;
    pre_nxt = pre_r + 21'h000001;
    tick_nxt = 1'b0;
    if (btn_s2_r != btn_q_r) begin
      if (deb_r == 19'(DEB_CYCLES - 1)) begin
        btn_q_nxt = btn_s2_r; // [RULE_14]
      end else begin
        deb_nxt = deb_r + 19'h00001;
      end
    end
    press_nxt = btn_q_nxt & ~btn_q_r;
    if (pre_r == 21'(TICK_CYCLES - 1)) begin
      pre_nxt = '0;
      tick_nxt = 1'b1; // [RULE_14]
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      btn_s1_r <= 1'b0;
      btn_s2_r <= 1'b0;
      dem_s1_r <= 1'b0;
      dem_s2_r <= 1'b0;
      btn_q_r <= 1'b0;
      press_r <= 1'b0;
      deb_r <= '0;
      pre_r <= '0;
      tick_r <= 1'b0;
    end else begin
      btn_s1_r <= I_RECALL_BTN;
      btn_s2_r <= btn_s1_r;
      dem_s1_r <= I_DEMAND;
      dem_s2_r <= dem_s1_r;
      btn_q_r <= btn_q_nxt;
      press_r <= press_nxt;
      deb_r <= deb_nxt;
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  // sequence, history and display state
  fhr_state_e st_r, st_nxt;
  logic [8:0] tmr_r, tmr_nxt;
  logic [2:0] idx_r, idx_nxt, cnt_r, cnt_nxt;
  logic [1:0] rep_r, rep_nxt;
  fhr_code_t hist_r [HIST_DEPTH];
  fhr_code_t hist_nxt [HIST_DEPTH];
  fhr_disp_s disp_r, disp_nxt;
  logic clr;
  logic [2:0] idx_up;

  assign idx_up = idx_r + 3'h1;

  // hold timing and review walk; demand always forces standby
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    idx_nxt = idx_r;
    rep_nxt = rep_r;
    cnt_nxt = cnt_r;
    hist_nxt = hist_r;
    clr = 1'b0;
    if (tick_r && tmr_r != '1) begin
      tmr_nxt = tmr_r + 9'h001; // [RULE_14]
    end
    unique case (st_r)
      ST_IDLE: begin
        if (press_r) begin
          st_nxt = ST_HOLD;
          tmr_nxt = '0;
        end
      end
      ST_HOLD: begin
        if (!btn_q_r) begin
          tmr_nxt = '0;
          if (tmr_r < T_REVIEW_LO) begin
            st_nxt = ST_IDLE; // [RULE_11]
          end else if (tmr_r < T_REVIEW_HI) begin
            idx_nxt = '0; // [RULE_05]
            rep_nxt = 2'h1;
            st_nxt = (cnt_r == '0) ? ST_END : ST_SHOW;
          end else if (tmr_r < T_CLEAR_LO) begin
            st_nxt = ST_IDLE; // [RULE_12]
          end else begin
            clr = 1'b1; // [RULE_10]
            st_nxt = ST_EIGHT;
          end
        end else if (tmr_r > T_CLEAR_HI) begin
          st_nxt = ST_IDLE; // [RULE_13]
        end
      end
      ST_SHOW: begin
        if (press_r) begin
          st_nxt = ST_NEXT; // [RULE_06]
        end else if (tmr_r >= T_REVIEW_OUT) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_NEXT: begin
        tmr_nxt = '0;
        if (idx_up >= cnt_r) begin
          st_nxt = ST_END; // [RULE_07]
        end else begin
          idx_nxt = idx_up;
          if (hist_r[idx_up] != hist_r[idx_r]) begin
            rep_nxt = 2'h1;
            st_nxt = ST_SHOW;
          end else if (rep_r != REPEAT_MAX) begin
            rep_nxt = rep_r + 2'h1;
            st_nxt = ST_SHOW;
          end // else skip this repeat and look again [RULE_08]
        end
      end
      ST_END: begin
        if (tmr_r >= T_END) begin
          st_nxt = ST_IDLE; // [RULE_07]
        end
      end
      ST_EIGHT: begin
        if (tmr_r >= T_EIGHTS) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
    if (dem_s2_r) begin
      st_nxt = ST_IDLE; // [RULE_03]
    end
    // a fault logged in the clearing cycle survives the clear
    if (clr) begin
      cnt_nxt = '0;
    end
    if (I_LOG_FAULT.valid) begin
      for (int i = HIST_DEPTH - 1; i > 0; i--) begin
        hist_nxt[i] = hist_r[i - 1];
      end
      hist_nxt[0] = I_LOG_FAULT.code; // [RULE_02]
      if (cnt_nxt != HIST_FULL) begin
        cnt_nxt = cnt_nxt + 3'h1;
      end
    end
  end

  // display selection; the entry under review is held through the step
  always_comb begin
    disp_nxt.lit = 1'b1;
    disp_nxt.kind = DK_BLANK;
    disp_nxt.code = CODE_RST;
    unique case (st_r)
      ST_IDLE: begin
        if (I_ACTIVE_FAULT.valid) begin
          disp_nxt.kind = DK_CODE; // [RULE_01]
          disp_nxt.code = I_ACTIVE_FAULT.code;
        end
      end
      ST_HOLD: begin
        if (tmr_r >= T_REVIEW_LO && tmr_r < T_REVIEW_HI) begin
          disp_nxt.kind = DK_DASH; // [RULE_04]
        end else if (tmr_r >= T_CLEAR_LO && tmr_r <= T_CLEAR_HI) begin
          disp_nxt.kind = DK_DASH; // [RULE_09]
          disp_nxt.lit = blink_on(tmr_r);
        end
      end
      ST_SHOW: begin
        disp_nxt.kind = DK_CODE; // [RULE_02]
        disp_nxt.code = hist_r[idx_r];
      end
      ST_NEXT: begin
        disp_nxt = disp_r;
      end
      ST_END: begin
        disp_nxt.kind = DK_DASH; // [RULE_07]
        disp_nxt.lit = blink_on(tmr_r);
      end
      ST_EIGHT: begin
        disp_nxt.kind = DK_EIGHT; // [RULE_10]
      end
    endcase
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      st_r <= ST_IDLE;
      tmr_r <= '0;
      idx_r <= '0;
      rep_r <= 2'h1;
      cnt_r <= '0;
      hist_r <= '{default: CODE_RST};
      disp_r <= '{lit: 1'b1, kind: DK_BLANK, code: CODE_RST};
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      idx_r <= idx_nxt;
      rep_r <= rep_nxt;
      cnt_r <= cnt_nxt;
      hist_r <= hist_nxt;
      disp_r <= disp_nxt;
    end
  end

  assign O_DISP = disp_r;
  assign O_HIST_COUNT = cnt_r;

  // checks on the sequence and display
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  a_idle_active_code: assert property ( // [RULE_01]
    st_r == ST_IDLE && I_ACTIVE_FAULT.valid |=>
      O_DISP.kind == DK_CODE && O_DISP.code == $past(I_ACTIVE_FAULT.code))
    else $error("active fault not shown in standby");

  a_hist_log_newest: assert property ( // [RULE_02]
    I_LOG_FAULT.valid |=>
      hist_r[0] == $past(I_LOG_FAULT.code) && cnt_r != '0 &&
      cnt_r <= HIST_FULL)
    else $error("logged fault not stored as newest");

  a_demand_blocks: assert property ( // [RULE_03]
    dem_s2_r |=> st_r == ST_IDLE)
    else $error("sequence runs during thermostat demand");

  a_review_dash: assert property ( // [RULE_04]
    st_r == ST_HOLD && tmr_r >= T_REVIEW_LO && tmr_r < T_REVIEW_HI |=>
      O_DISP.kind == DK_DASH && O_DISP.lit)
    else $error("steady dash missing in review window");

  a_first_show: assert property ( // [RULE_05]
    st_r == ST_HOLD && !btn_q_r && !dem_s2_r && cnt_r != '0 &&
    tmr_r >= T_REVIEW_LO && tmr_r < T_REVIEW_HI |=>
      st_r == ST_SHOW && idx_r == '0 ##1 O_DISP.kind == DK_CODE)
    else $error("newest fault not shown after review release");

  a_press_steps: assert property ( // [RULE_06]
    st_r == ST_SHOW && press_r && !dem_s2_r |=> st_r == ST_NEXT)
    else $error("press did not step the review");

  a_series_end: assert property ( // [RULE_07]
    st_r == ST_NEXT && idx_up >= cnt_r && !dem_s2_r |=>
      st_r == ST_END ##1 O_DISP.kind == DK_DASH)
    else $error("end of review not marked by dashes");

  a_repeat_cap: assert property ( // [RULE_08]
    st_r == ST_SHOW |-> rep_r != '0 && rep_r <= REPEAT_MAX)
    else $error("repeated fault shown too often");

  a_clear_armed: assert property ( // [RULE_09]
    st_r == ST_HOLD && tmr_r >= T_CLEAR_LO && tmr_r <= T_CLEAR_HI |=>
      O_DISP.kind == DK_DASH && O_DISP.lit == blink_on($past(tmr_r)))
    else $error("armed clear does not blink dashes");

  a_clear_done: assert property ( // [RULE_10]
    st_r == ST_HOLD && !btn_q_r && !dem_s2_r && !I_LOG_FAULT.valid &&
    tmr_r >= T_CLEAR_LO && tmr_r <= T_CLEAR_HI |=>
      cnt_r == '0 ##1 O_DISP.kind == DK_EIGHT)
    else $error("clear release did not erase and show 88");

  a_short_abort: assert property ( // [RULE_11]
    st_r == ST_HOLD && !btn_q_r && tmr_r < T_REVIEW_LO |=>
      st_r == ST_IDLE && $stable(idx_r))
    else $error("short hold did not return to standby");

  a_mid_abort: assert property ( // [RULE_12]
    st_r == ST_HOLD && !btn_q_r && tmr_r >= T_REVIEW_HI &&
    tmr_r < T_CLEAR_LO && !I_LOG_FAULT.valid |=>
      st_r == ST_IDLE && $stable(cnt_r))
    else $error("mid hold release took an action");

  a_long_cancel: assert property ( // [RULE_13]
    st_r == ST_HOLD && btn_q_r && tmr_r > T_CLEAR_HI &&
    !I_LOG_FAULT.valid |=> st_r == ST_IDLE && $stable(cnt_r))
    else $error("overlong hold did not cancel the clear");

  a_debounce_hold: assert property ( // [RULE_14]
    btn_q_r != $past(btn_q_r) |-> $past(deb_r) == 19'(DEB_CYCLES - 1))
    else $error("button level changed before debounce window");

endmodule

// ---- verification/fhr_tech.sv ----
// technician model: drives the recall push-button with contact bounce
`timescale 1ns/100ps
module fhr_tech (
  // clock
  input wire logic i_clk,
  // button pin, high while pressed
  output logic o_btn
);
  initial o_btn = 1'b0;
  // contacts chatter on make, so a press bounces once
  task automatic press_btn();
    @(posedge i_clk) o_btn <= 1'b1;
    @(posedge i_clk) o_btn <= 1'b0;
    @(posedge i_clk) o_btn <= 1'b1;
  endtask
  // break is clean
  task automatic release_btn();
    @(posedge i_clk) o_btn <= 1'b0;
  endtask
  // one-cycle dropout while held, far shorter than the debounce window
  task automatic glitch_btn();
    @(posedge i_clk) o_btn <= 1'b0;
    @(posedge i_clk) o_btn <= 1'b1;
  endtask
endmodule

// ---- verification/fhr_recall_bench.sv ----
// self-checking bench for the fault history recall controller
`timescale 1ns/100ps
module fhr_recall_bench
  import fhr_pkg::*;
;
  // short tick keeps a 15 s hold near 3000 cycles
  localparam int TK = 20;
  logic clk;
  logic rst;
  logic btn;
  logic dem;
  fhr_fault_s act;
  fhr_fault_s lg;
  fhr_disp_s disp;
  logic [2:0] cnt;
  int error_cnt = 0;
  int n_checks = 0;

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  fhr_recall #(.TICK_CYCLES(TK), .DEB_CYCLES(4)) i_fhr_recall (
    .I_MCLK(clk),
    .I_RST(rst),
    .I_RECALL_BTN(btn),
    .I_DEMAND(dem),
    .I_ACTIVE_FAULT(act),
    .I_LOG_FAULT(lg),
    .O_DISP(disp),
    .O_HIST_COUNT(cnt)
  );
  fhr_tech i_fhr_tech (.i_clk(clk), .o_btn(btn));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // lit is masked: blink phase is judged apart
  task automatic chk_disp(input fhr_kind_e k, input fhr_code_t c);
    #1;
    n_checks++;
    if ({disp.kind, disp.code} !== {k, c}) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time,
        {disp.kind, disp.code}, {k, c});
    end
  endtask

  task automatic chk_cnt(input logic [2:0] e);
    #1;
    n_checks++;
    if (cnt !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, cnt, e);
    end
  endtask

  // a blinking pattern must show a dark phase within 1.2 s
  // sampled 1 ns after each edge so the registered output has settled
  task automatic chk_dark();
    int i;
    i = 0;
    #1;
    while (i < 12 * TK && disp.lit !== 1'b0) begin
      cyc(1);
      #1;
      i++;
    end
    n_checks++;
    if (disp.lit !== 1'b0) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, disp.lit, 1'b0);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // hold t tenths, optional look at tenth m, settle 0.3 s after release
  task automatic hold(input int t, input int m, input fhr_kind_e mk);
    i_fhr_tech.press_btn();
    cyc(m * TK);
    if (m > 0) chk_disp(mk, CODE_RST);
    if (m >= 100) chk_dark();
    cyc((t - m) * TK);
    i_fhr_tech.release_btn();
    cyc(3 * TK);
  endtask

  task automatic step(input fhr_kind_e k, input fhr_code_t c);
    i_fhr_tech.press_btn();
    cyc(TK);
    i_fhr_tech.release_btn();
    cyc(TK);
    chk_disp(k, c);
  endtask

  task automatic t_active();
    @(posedge clk) act <= {1'b1, 8'h3A};
    cyc(5);
    chk_disp(DK_CODE, 8'h3A);
    @(posedge clk) act <= '0;
    cyc(5);
    chk_disp(DK_BLANK, CODE_RST);
    done("active");
  endtask

  // seven back-to-back logs: the oldest falls out, a run of four 22s
  task automatic t_log();
    fhr_code_t q[7] = '{8'h20, 8'h21, 8'h22, 8'h22, 8'h22, 8'h22, 8'h23};
    foreach (q[i]) begin
      @(posedge clk) lg <= {1'b1, q[i]};
    end
    @(posedge clk) lg <= '0;
    cyc(2);
    chk_cnt(3'h6);
    done("log");
  endtask

  task automatic t_review();
    hold(40, 35, DK_DASH);
    chk_disp(DK_CODE, 8'h23);
    step(DK_CODE, 8'h22);
    step(DK_CODE, 8'h22);
    step(DK_CODE, 8'h22);
    step(DK_CODE, 8'h21);
    step(DK_DASH, CODE_RST);
    chk_dark();
    cyc(32 * TK);
    chk_disp(DK_BLANK, CODE_RST);
    done("review");
  endtask

  task automatic t_refused();
    @(posedge clk) dem <= 1'b1;
    cyc(4);
    hold(40, 0, DK_BLANK);
    chk_disp(DK_BLANK, CODE_RST);
    @(posedge clk) dem <= 1'b0;
    cyc(4);
    hold(10, 0, DK_BLANK);
    chk_disp(DK_BLANK, CODE_RST);
    hold(70, 60, DK_BLANK);
    chk_disp(DK_BLANK, CODE_RST);
    chk_cnt(3'h6);
    hold(160, 0, DK_BLANK);
    chk_disp(DK_BLANK, CODE_RST);
    chk_cnt(3'h6);
    done("refused");
  endtask

  task automatic t_clear();
    hold(125, 105, DK_DASH);
    chk_disp(DK_EIGHT, CODE_RST);
    chk_cnt(3'h0);
    cyc(32 * TK);
    // review of an empty history goes straight to the end dashes
    hold(40, 35, DK_DASH);
    chk_disp(DK_DASH, CODE_RST);
    cyc(32 * TK);
    chk_disp(DK_BLANK, CODE_RST);
    done("clear");
  endtask

  // a dropout mid-hold must not count as a release
  task automatic t_bounce();
    i_fhr_tech.press_btn();
    cyc(30 * TK);
    i_fhr_tech.glitch_btn();
    cyc(5 * TK);
    chk_disp(DK_DASH, CODE_RST);
    i_fhr_tech.release_btn();
    cyc(3 * TK);
    chk_disp(DK_CODE, 8'h23);
    @(posedge clk) dem <= 1'b1;
    cyc(6);
    chk_disp(DK_BLANK, CODE_RST);
    @(posedge clk) dem <= 1'b0;
    cyc(4);
    done("bounce");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    dem = 1'b0;
    act = '0;
    lg = '0;
    cyc(8);
    rst <= 1'b0;
    cyc(4);
    t_active();
    t_log();
    t_review();
    t_refused();
    t_bounce();
    t_clear();
    print_verdict();
  end

  // watchdog: the tests need about 13000 cycles
  initial begin
    cyc(40000);
    error_cnt++;
    print_verdict();
  end
endmodule
